//--- rtl/tpl_telemetry_peak_log.sv
// Functional notes
// - Output voltage word: 5-bit exponent over 11-bit mantissa.
// - Write to read-only command sets fault flags and raises alert.
// - Input current record: minimum in upper half, maximum in lower.
// - Input power record same layout, resets to zero.
// - Output power record same layout, kept per page.
// - Codes 1,2,4 pause min, pause max, pause both.
// - Codes 8,10h,20h each resume both min and max.
// - Codes 40h,80h,100h clear min, max, both; others invalid.
// - Logging runs from reset; only host commands pause and resume it.
// - Command DAh returns 14-byte telemetry block, read only.
// - Telemetry order: pin, pout, temp1, iin, vin, iout, vout.
// - Command DBh returns 18-byte paged status block, read only.
// Top of the telemetry peak log command block
// Holds the input current, input power and per-page output power peak records,
// the measured output voltage word and the two combined block reads
// Assumes a protocol engine delivers decoded commands with one-cycle strobes
// Assumes i_rd and i_wr never stand together and i_page stays below PAGES
// Assumes every telemetry input is settled whenever i_smp_vld is high
// A read of a command outside this block gives no answer strobe
`timescale 1ns/1ps
`include "tpl_defines.svh"
module tpl_telemetry_peak_log #(
    parameter int PAGES = 2
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_b,
    input  wire logic [7:0]           i_cmd,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire tpl_pkg::tpl_rec_t    i_wdata,
    input  wire logic                 i_page,
    input  wire logic                 i_smp_vld,
    input  wire tpl_pkg::tpl_word_t   i_pin,
    input  wire tpl_pkg::tpl_word_t   i_iin,
    input  wire tpl_pkg::tpl_word_t   i_vin,
    input  wire tpl_pkg::tpl_word_t   i_temp1,
    input  wire tpl_pkg::tpl_word_t   i_pout   [PAGES],
    input  wire tpl_pkg::tpl_word_t   i_iout   [PAGES],
    input  wire logic [4:0]           i_vout_exp [PAGES],
    input  wire logic [10:0]          i_vout_man [PAGES],
    input  wire logic [143:0]         i_status [PAGES],
    input  wire logic                 i_fault_clr,
    output logic [143:0]              o_rdata,
    output logic [7:0]                o_rcount,
    output logic                      o_rvalid,
    output logic                      o_bad_data,
    output logic                      o_communication_fault_flag,
    output logic                      o_other_communication_fault_flag,
    output logic                      o_alert_b
);
    import tpl_pkg::*;

    // ****************************************
    // Command decode
    // ****************************************
    // True for the commands that only answer reads; a write to one is a fault
    function automatic logic cmd_is_ro(input logic [7:0] c);
        cmd_is_ro = (c == `TPL_CMD_VOUT) || (c == `TPL_CMD_TELEM) || (c == `TPL_CMD_STATUS);
    endfunction

    // True for a write strobe aimed at the wanted peak record command
    function automatic logic pk_wr(input logic wr, input logic [7:0] c, input logic [7:0] want);
        pk_wr = wr && (c == want);
    endfunction

    // Byte count answered for a read of command c, none for foreign codes
    function automatic logic [7:0] rd_bytes(input logic [7:0] c);
        case (c)
            `TPL_CMD_VOUT:    rd_bytes = `TPL_VOUT_BYTES;
            `TPL_CMD_IIN_PK,
            `TPL_CMD_PIN_PK,
            `TPL_CMD_POUT_PK: rd_bytes = `TPL_PEAK_BYTES;
            `TPL_CMD_TELEM:   rd_bytes = `TPL_TELEM_BYTES;
            `TPL_CMD_STATUS:  rd_bytes = `TPL_STATUS_BYTES;
            default:          rd_bytes = `TPL_NO_BYTES;
        endcase
    endfunction

    // ****************************************
    // Peak records
    // ****************************************
    tpl_rec_t rec_iin, rec_pin;
    tpl_rec_t rec_pout [PAGES];
    logic     bad_iin, bad_pin;
    logic     bad_pout [PAGES];
    logic     bad_any;

    // Input current record, fed by i_iin on each valid sample
    tpl_peak_log u_iin (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (i_rst_b),
        .i_smp_vld  (i_smp_vld),
        .i_smp      (i_iin),
        .i_wr       (pk_wr(i_wr, i_cmd, `TPL_CMD_IIN_PK)),
        .i_wdata    (i_wdata),
        .o_bad_code (bad_iin),
        .o_rec      (rec_iin)
    );
    // Input power record, not paged
    tpl_peak_log u_pin (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (i_rst_b),
        .i_smp_vld  (i_smp_vld),
        .i_smp      (i_pin),
        .i_wr       (pk_wr(i_wr, i_cmd, `TPL_CMD_PIN_PK)),
        .i_wdata    (i_wdata),
        .o_bad_code (bad_pin),
        .o_rec      (rec_pin)
    );
    // One output power record per page
    for (genvar g = 0; g < PAGES; g++) begin : g_pout
        tpl_peak_log u_pout (
            .i_ref_clk  (i_ref_clk),
            .i_rst_b    (i_rst_b),
            .i_smp_vld  (i_smp_vld),
            .i_smp      (i_pout[g]),
            .i_wr       (pk_wr(i_wr, i_cmd, `TPL_CMD_POUT_PK) && int'(i_page) == g),
            .i_wdata    (i_wdata),
            .o_bad_code (bad_pout[g]),
            .o_rec      (rec_pout[g])
        );
    end

    // Any invalid control code seen
    always_comb begin
        bad_any = bad_iin | bad_pin;
        for (int k = 0; k < PAGES; k++) bad_any = bad_any | bad_pout[k];
    end

    // ****************************************
    // Read data, byte count and answer strobe
    // ****************************************
    logic [143:0] rdata_r, rdata_nxt;
    logic [7:0]   rcnt_r, rcnt_nxt;
    logic         rvld_r, rvld_nxt;
    tpl_word_t    vout_w;

    // Measured output voltage of the selected page, exponent over mantissa
    assign vout_w = {i_vout_exp[i_page], i_vout_man[i_page]};

    // Read mux; data and count hold between answers, the strobe lasts one cycle
    always_comb begin
        rdata_nxt = rdata_r;
        rcnt_nxt  = rcnt_r;
        rvld_nxt  = 1'b0;
        if (i_rd && rd_bytes(i_cmd) != `TPL_NO_BYTES) begin
            rvld_nxt  = 1'b1;
            rdata_nxt = '0;
            rcnt_nxt  = rd_bytes(i_cmd);
            case (i_cmd)
                `TPL_CMD_VOUT:    rdata_nxt[15:0] = vout_w;
                `TPL_CMD_IIN_PK:  rdata_nxt[31:0] = rec_iin;
                `TPL_CMD_PIN_PK:  rdata_nxt[31:0] = rec_pin;
                `TPL_CMD_POUT_PK: rdata_nxt[31:0] = rec_pout[i_page];
                `TPL_CMD_TELEM:   begin
                    rdata_nxt[111:0] = {i_pin, i_pout[i_page], i_temp1, i_iin, i_vin,
                                        i_iout[i_page], vout_w};
                end
                `TPL_CMD_STATUS:  rdata_nxt = i_status[i_page];
                default:          rdata_nxt = '0;
            endcase
        end
    end

    // Read registers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= '0;
            rcnt_r  <= `TPL_NO_BYTES;
            rvld_r  <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rcnt_r  <= rcnt_nxt;
            rvld_r  <= rvld_nxt;
        end
    end

    // ****************************************
    // Fault flags and alert
    // ****************************************
    logic cml_r, cml_nxt, oth_r, oth_nxt;
    logic alert_r, alert_nxt, bad_r, bad_nxt;
    logic ro_wr;

    // A write strobe aimed at any command that only answers reads
    assign ro_wr = i_wr && cmd_is_ro(i_cmd);

    // Sticky flags; a fault in the clearing cycle wins so that none is lost
    always_comb begin
        cml_nxt   = ro_wr | (cml_r & ~i_fault_clr);
        oth_nxt   = ro_wr | (oth_r & ~i_fault_clr);
        alert_nxt = ~(cml_nxt | oth_nxt);
        bad_nxt   = bad_any;
    end

    // Fault registers; alert idles high out of reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cml_r   <= 1'b0;
            oth_r   <= 1'b0;
            alert_r <= 1'b1;
            bad_r   <= 1'b0;
        end else begin
            cml_r   <= cml_nxt;
            oth_r   <= oth_nxt;
            alert_r <= alert_nxt;
            bad_r   <= bad_nxt;
        end
    end

    // ****************************************
    // Outputs, each straight from its register
    // ****************************************
    assign o_rdata                          = rdata_r;
    assign o_rcount                         = rcnt_r;
    assign o_rvalid                         = rvld_r;
    assign o_bad_data                       = bad_r;
    assign o_communication_fault_flag       = cml_r;
    assign o_other_communication_fault_flag = oth_r;
    assign o_alert_b                        = alert_r;
endmodule

//--- rtl/tpl_defines.svh
// Command codes, control codes, field positions and reset values of the peak log block
// Assumes nothing beyond being included by the package and the design files
`ifndef TPL_DEFINES_SVH
`define TPL_DEFINES_SVH
`define TPL_CMD_VOUT       8'hD4
`define TPL_CMD_IIN_PK     8'hD6
`define TPL_CMD_PIN_PK     8'hD7
`define TPL_CMD_POUT_PK    8'hD8
`define TPL_CMD_TELEM      8'hDA
`define TPL_CMD_STATUS     8'hDB
`define TPL_CODE_PMIN      32'h0000_0001
`define TPL_CODE_PMAX      32'h0000_0002
`define TPL_CODE_PBOTH     32'h0000_0004
`define TPL_CODE_RMIN      32'h0000_0008
`define TPL_CODE_RMAX      32'h0000_0010
`define TPL_CODE_RBOTH     32'h0000_0020
`define TPL_CODE_CMIN      32'h0000_0040
`define TPL_CODE_CMAX      32'h0000_0080
`define TPL_CODE_CBOTH     32'h0000_0100
`define TPL_PEAK_RST       16'h0000
`define TPL_EXP_MSB        15
`define TPL_EXP_LSB        11
`define TPL_MAN_MSB        10
`define TPL_MIN_MSB        31
`define TPL_MIN_LSB        16
`define TPL_MAX_MSB        15
`define TPL_NO_BYTES       8'h00
`define TPL_VOUT_BYTES     8'h02
`define TPL_PEAK_BYTES     8'h04
`define TPL_TELEM_BYTES    8'h0E
`define TPL_STATUS_BYTES   8'h12
`endif

//--- rtl/tpl_pkg.sv
// Types shared by the peak log files
// Assumes tpl_defines.svh is on the include path
`include "tpl_defines.svh"
package tpl_pkg;
    typedef logic [15:0] tpl_word_t;
    typedef logic [31:0] tpl_rec_t;
    typedef enum logic [1:0] {
        TPL_IDLE  = 2'b00,
        TPL_TRACK = 2'b01,
        TPL_PAUSE = 2'b11
    } tpl_side_t;
endpackage

//--- rtl/tpl_peak_log.sv
// One min/max peak record with its pause, resume and reset controls
// Assumes samples are signed linear words and a write strobe lasts one cycle
`timescale 1ns/1ps
`include "tpl_defines.svh"
module tpl_peak_log (
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst_b,
    input  wire logic            i_smp_vld,
    input  wire tpl_pkg::tpl_word_t i_smp,
    input  wire logic            i_wr,
    input  wire tpl_pkg::tpl_rec_t  i_wdata,
    output logic                 o_bad_code,
    output tpl_pkg::tpl_rec_t    o_rec
);
    import tpl_pkg::*;

    tpl_word_t min_r, min_nxt, max_r, max_nxt;
    logic      pmin_r, pmin_nxt, pmax_r, pmax_nxt, init_r, init_nxt, bad_r, bad_nxt;

    // Signed comparison of two linear words by exponent scaled value
    function automatic logic lin_lt(input tpl_word_t a, input tpl_word_t b);
        logic signed [47:0] va, vb;
        va = 48'(signed'(a[`TPL_MAN_MSB:0])) <<< (5'(a[`TPL_EXP_MSB:`TPL_EXP_LSB]) + 5'd16);
        vb = 48'(signed'(b[`TPL_MAN_MSB:0])) <<< (5'(b[`TPL_EXP_MSB:`TPL_EXP_LSB]) + 5'd16);
        lin_lt = va < vb;
    endfunction

    // Control decode and tracking
    always_comb begin
        min_nxt  = min_r;
        max_nxt  = max_r;
        pmin_nxt = pmin_r;
        pmax_nxt = pmax_r;
        init_nxt = init_r;
        bad_nxt  = 1'b0;
        if (i_smp_vld) begin
            if (!pmin_r && (init_r || lin_lt(i_smp, min_r))) min_nxt = i_smp;
            if (!pmax_r && (init_r || lin_lt(max_r, i_smp))) max_nxt = i_smp;
            init_nxt = 1'b0;
        end
        if (i_wr) begin
            case (i_wdata)
                `TPL_CODE_PMIN:  begin pmin_nxt = 1'b1; pmax_nxt = 1'b0; end
                `TPL_CODE_PMAX:  begin pmax_nxt = 1'b1; pmin_nxt = 1'b0; end
                `TPL_CODE_PBOTH: begin pmin_nxt = 1'b1; pmax_nxt = 1'b1; end
                `TPL_CODE_RMIN,
                `TPL_CODE_RMAX,
                `TPL_CODE_RBOTH: begin pmin_nxt = 1'b0; pmax_nxt = 1'b0; end
                `TPL_CODE_CMIN:  min_nxt = `TPL_PEAK_RST;
                `TPL_CODE_CMAX:  max_nxt = `TPL_PEAK_RST;
                `TPL_CODE_CBOTH: begin min_nxt = `TPL_PEAK_RST; max_nxt = `TPL_PEAK_RST; end
                default:         bad_nxt = 1'b1;
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            min_r  <= `TPL_PEAK_RST;
            max_r  <= `TPL_PEAK_RST;
            pmin_r <= 1'b0;
            pmax_r <= 1'b0;
            init_r <= 1'b1;
            bad_r  <= 1'b0;
        end else begin
            min_r  <= min_nxt;
            max_r  <= max_nxt;
            pmin_r <= pmin_nxt;
            pmax_r <= pmax_nxt;
            init_r <= init_nxt;
            bad_r  <= bad_nxt;
        end
    end

    assign o_rec      = {min_r, max_r};
    assign o_bad_code = bad_r;
endmodule

//--- bench/tpl_chk_asserts.sv
// Concurrent checks on the ports of the peak log command block
// Assumes binding to tpl_telemetry_peak_log and one clock domain
`timescale 1ns/1ps
`include "tpl_defines.svh"
module tpl_chk_asserts (
    input wire logic              i_ref_clk,
    input wire logic              i_rst_b,
    input wire logic [7:0]        i_cmd,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire tpl_pkg::tpl_rec_t i_wdata,
    input wire logic              i_fault_clr,
    input wire logic [7:0]        o_rcount,
    input wire logic              o_rvalid,
    input wire logic              o_bad_data,
    input wire logic              o_communication_fault_flag,
    input wire logic              o_other_communication_fault_flag,
    input wire logic              o_alert_b
);
    import tpl_pkg::*;
    // ****************************************************************
    // Command decode helpers and properties
    // ****************************************************************
    logic ro_w;
    logic pk_w;
    logic ok_w;
    assign ro_w = i_cmd inside {`TPL_CMD_VOUT, `TPL_CMD_TELEM, `TPL_CMD_STATUS};
    assign pk_w = i_cmd inside {`TPL_CMD_IIN_PK, `TPL_CMD_PIN_PK, `TPL_CMD_POUT_PK};
    assign ok_w = i_wdata inside {`TPL_CODE_PMIN, `TPL_CODE_PMAX,
        `TPL_CODE_PBOTH, `TPL_CODE_RMIN, `TPL_CODE_RMAX, `TPL_CODE_RBOTH,
        `TPL_CODE_CMIN, `TPL_CODE_CMAX, `TPL_CODE_CBOTH};
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    a_ro_write_faults: assert property (i_wr && ro_w |=> o_communication_fault_flag
        && o_other_communication_fault_flag) else $error("read-only write not flagged");
    a_fault_alert_low: assert property (o_communication_fault_flag
        && $past(o_communication_fault_flag) |-> !o_alert_b) else $error("alert not low");
    a_fault_flag_sticky: assert property (o_communication_fault_flag && !i_fault_clr
        |=> o_communication_fault_flag) else $error("fault flag dropped");
    a_bad_code_pulse: assert property (i_wr && pk_w && !ok_w |-> ##2 o_bad_data)
        else $error("invalid code not reported");
    a_good_code_quiet: assert property (i_wr && pk_w && ok_w |-> ##2 !o_bad_data)
        else $error("valid code reported bad");
    a_telem_count: assert property (i_rd && i_cmd == `TPL_CMD_TELEM |=> o_rvalid
        && o_rcount == `TPL_TELEM_BYTES) else $error("telemetry count wrong");
    a_status_count: assert property (i_rd && i_cmd == `TPL_CMD_STATUS |=> o_rvalid
        && o_rcount == `TPL_STATUS_BYTES) else $error("status count wrong");
    a_peak_count: assert property (i_rd && pk_w |=> o_rvalid
        && o_rcount == `TPL_PEAK_BYTES) else $error("peak count wrong");
    a_vout_count: assert property (i_rd && i_cmd == `TPL_CMD_VOUT |=> o_rvalid
        && o_rcount == `TPL_VOUT_BYTES) else $error("vout count wrong");
    a_quiet_rvalid: assert property (!i_rd |=> !o_rvalid) else $error("stray rvalid");
    c_ro_write: cover property (i_wr && ro_w);
    c_bad_code: cover property (o_bad_data);
    c_telem_read: cover property (o_rvalid && o_rcount == `TPL_TELEM_BYTES);
endmodule
bind tpl_telemetry_peak_log tpl_chk_asserts tpl_chk_asserts_inst (.i_ref_clk, .i_rst_b,
    .i_cmd, .i_wr, .i_rd, .i_wdata, .i_fault_clr, .o_rcount, .o_rvalid, .o_bad_data,
    .o_communication_fault_flag, .o_other_communication_fault_flag, .o_alert_b);

//--- bench/tpl_host_model.sv
// Host side of the command port: issues word and block commands
// Assumes the design takes one-cycle strobes at the rising edge
`timescale 1ns/1ps
module tpl_host_model (
    input  wire logic              i_ref_clk,
    input  wire logic [143:0]      i_rdata,
    input  wire logic [7:0]        i_rcount,
    input  wire logic              i_rvalid,
    output logic [7:0]             o_cmd,
    output logic                   o_wr,
    output logic                   o_rd,
    output tpl_pkg::tpl_rec_t      o_wdata
);
    import tpl_pkg::*;
    // ****************************************************************
    // Command tasks; logging runs from reset, only the host pauses or resumes it
    // ****************************************************************
    initial begin
        o_cmd = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 32'h0;
    end
    // Write strobe; command and data inverted once released
    task automatic wr(input logic [7:0] c, input tpl_rec_t d);
        @(negedge i_ref_clk);
        o_cmd = c;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_ref_clk);
        o_wr = 1'b0;
        o_cmd = ~c;
        o_wdata = ~d;
    endtask
    // Read strobe; answer taken while rvalid stands
    task automatic rd(input logic [7:0] c, output logic [143:0] d, output logic [7:0] n,
                      output logic v);
        @(negedge i_ref_clk);
        o_cmd = c;
        o_rd = 1'b1;
        @(negedge i_ref_clk);
        o_rd = 1'b0;
        o_cmd = ~c;
        d = i_rdata;
        n = i_rcount;
        v = i_rvalid;
    endtask
endmodule

//--- bench/tb.sv
// Self-checking bench of the peak log command block
// Assumes the host model drives the command port at falling edges
`timescale 1ns/1ps
module tb;
    import tpl_pkg::*;
    // ****************************************************************
    // Signals, clock, instances
    // ****************************************************************
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_cmd, o_rcount;
    logic i_wr, i_rd, i_page = 1'b0, i_smp_vld = 1'b0, i_fault_clr = 1'b0;
    logic o_rvalid, o_bad_data, o_cf, o_ocf, o_alert_b;
    tpl_rec_t i_wdata;
    tpl_word_t i_pin = 16'h0, i_iin = 16'h0, i_vin = 16'h3333, i_temp1 = 16'h4444;
    tpl_word_t i_pout [2] = '{16'h0000, 16'h0055};
    tpl_word_t i_iout [2] = '{16'h1111, 16'h2222};
    logic [4:0] i_vout_exp [2] = '{5'h1D, 5'h02};
    logic [10:0] i_vout_man [2] = '{11'h123, 11'h456};
    logic [143:0] i_status [2] = '{{9{16'hA5C3}}, {9{16'h3C5A}}};
    logic [143:0] o_rdata;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] ro [3] = '{8'hD4, 8'hDA, 8'hDB};
    always #20 i_ref_clk = ~i_ref_clk;
    tpl_telemetry_peak_log tpl_telemetry_peak_log_inst (.i_ref_clk, .i_rst_b, .i_cmd, .i_wr,
        .i_rd, .i_wdata, .i_page, .i_smp_vld, .i_pin, .i_iin, .i_vin, .i_temp1, .i_pout,
        .i_iout, .i_vout_exp, .i_vout_man, .i_status, .i_fault_clr, .o_rdata, .o_rcount,
        .o_rvalid, .o_bad_data, .o_communication_fault_flag(o_cf),
        .o_other_communication_fault_flag(o_ocf), .o_alert_b);
    tpl_host_model tpl_host_model_inst (.i_ref_clk, .i_rdata(o_rdata), .i_rcount(o_rcount),
        .i_rvalid(o_rvalid), .o_cmd(i_cmd), .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
    // ****************************************************************
    // Compare, read, sample and closing tasks
    // ****************************************************************
    task automatic chk(input logic [143:0] seen, input logic [143:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdk(input logic [7:0] c, input logic [143:0] e, input logic [7:0] n = 8'h04);
        logic [143:0] d;
        logic [7:0] k;
        logic v;
        tpl_host_model_inst.rd(c, d, k, v);
        chk(v, 1'b1);
        chk(k, n);
        chk(d, e);
    endtask
    task automatic smp(input tpl_word_t v);
        @(negedge i_ref_clk);
        i_pin = v;
        i_iin = v;
        i_pout[0] = v;
        i_smp_vld = 1'b1;
        @(negedge i_ref_clk);
        i_smp_vld = 1'b0;
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 3000);
        n_errors++;
        wrap_up();
    end
    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        chk({o_cf, o_ocf, o_alert_b}, 3'b001);
        rdk(8'hD6, 32'h0);
        rdk(8'hD7, 32'h0);
        rdk(8'hD8, 32'h0);
        smp(16'h0010);
        smp(16'h0020);
        smp(16'h0008);
        rdk(8'hD6, 32'h0008_0020);
        tpl_host_model_inst.wr(8'hD6, 32'h1);
        smp(16'h0004);
        smp(16'h0030);
        rdk(8'hD6, 32'h0008_0030);
        tpl_host_model_inst.wr(8'hD6, 32'h8);
        smp(16'h0002);
        rdk(8'hD6, 32'h0002_0030);
        tpl_host_model_inst.wr(8'hD6, 32'h2);
        smp(16'h0040);
        rdk(8'hD6, 32'h0002_0030);
        tpl_host_model_inst.wr(8'hD6, 32'h10);
        smp(16'h0041);
        rdk(8'hD6, 32'h0002_0041);
        tpl_host_model_inst.wr(8'hD6, 32'h4);
        smp(16'h0001);
        smp(16'h0050);
        rdk(8'hD6, 32'h0002_0041);
        tpl_host_model_inst.wr(8'hD6, 32'h20);
        smp(16'h0001);
        rdk(8'hD6, 32'h0001_0041);
        tpl_host_model_inst.wr(8'hD6, 32'h40);
        rdk(8'hD6, 32'h0000_0041);
        tpl_host_model_inst.wr(8'hD6, 32'h80);
        smp(16'h0006);
        rdk(8'hD6, 32'h0000_0006);
        tpl_host_model_inst.wr(8'hD6, 32'h100);
        tpl_host_model_inst.wr(8'hD6, 32'h3);
        @(negedge i_ref_clk);
        chk(o_bad_data, 1'b1);
        rdk(8'hD6, 32'h0);
        rdk(8'hD7, 32'h0001_0050);
        rdk(8'hD8, 32'h0001_0050);
        i_page = 1'b1;
        rdk(8'hD8, 32'h0055_0055);
        rdk(8'hDA, 112'h0006_0055_4444_0006_3333_2222_1456, 8'h0E);
        rdk(8'hD4, 16'h1456, 8'h02);
        rdk(8'hDB, i_status[1], 8'h12);
        i_page = 1'b0;
        rdk(8'hDB, i_status[0], 8'h12);
        rdk(8'hD4, 16'hE923, 8'h02);
        // Scaled compare: -1, then 20 at exponent -1, then 21 at exponent 2
        smp(16'h07FF);
        smp(16'hF814);
        smp(16'h1015);
        rdk(8'hD7, 32'h07FF_1015);
        rdk(8'hD6, 32'h07FF_1015);
        foreach (ro[i]) begin
            tpl_host_model_inst.wr(ro[i], 32'h0);
            @(negedge i_ref_clk);
            chk({o_cf, o_ocf, o_alert_b}, 3'b110);
            i_fault_clr = 1'b1;
            @(negedge i_ref_clk);
            i_fault_clr = 1'b0;
            @(negedge i_ref_clk);
            chk({o_cf, o_ocf, o_alert_b}, 3'b001);
        end
        // A fault raised in the clearing cycle survives it, then clears
        i_fault_clr = 1'b1;
        tpl_host_model_inst.wr(8'hDB, 32'h0);
        chk({o_cf, o_ocf, o_alert_b}, 3'b110);
        @(negedge i_ref_clk);
        chk({o_cf, o_ocf, o_alert_b}, 3'b001);
        i_fault_clr = 1'b0;
        wrap_up();
    end
endmodule
